// ### inc/gsc_pkg.sv
// shared constants and types of the generator synchronizer control block
package gsc_pkg;
    // clock and program cycle timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PROG_CYCLE_US = 5000;
    localparam int PROG_CYCLE_CLKS = PROG_CYCLE_US * (1000000 / CLK_PERIOD_PS);
    // least lead of the blocking source before the operating delay ends
    localparam int BLOCK_LEAD_US = 5000;
    // widths
    localparam int SET_W = 16;
    localparam int ACC_W = 24;
    localparam int LEN_W = 20;
    localparam int TIME_W = 20;
    localparam int STAMP_W = 32;
    localparam int PROD_W = 32;
    // scaling of pulse length and of the close lead projection
    localparam int LEN_SHIFT = 10;
    localparam int PRE_SHIFT = 7;
    // setting defaults, units of 0.01 (% of nominal_voltage, Hz, plain); the pulse constant in 1/1024 program cycles
    localparam logic [SET_W-1:0] DEF_VDIFF_MAX = 16'h07D0;
    localparam logic [SET_W-1:0] DEF_VUP_LIM = 16'h07D0;
    localparam logic [SET_W-1:0] DEF_VDN_LIM = 16'hF830;
    localparam logic [SET_W-1:0] DEF_VINT_THR = 16'h03E8;
    localparam logic [LEN_W-1:0] DEF_PULSE_CONST = 20'h186A0;
    localparam logic [SET_W-1:0] DEF_FDIFF_MAX = 16'h01F4;
    localparam logic [SET_W-1:0] DEF_FINT_THR = 16'h0064;
    localparam logic [SET_W-1:0] DEF_PRECLOSE = 16'h000A;
    // filter time in program cycles (one step of 5 ms each)
    localparam logic [TIME_W-1:0] DEF_FILT_CYCLES = 20'h000C8;
    // event bit positions of the status vector
    localparam int EV_BLOCKED = 0;
    localparam int EV_RUNNING = 1;
    localparam int EV_VRAISE = 2;
    localparam int EV_VLOWER = 3;
    localparam int EV_FRAISE = 4;
    localparam int EV_FLOWER = 5;
    localparam int EV_CLOSE = 6;
    localparam int EV_LONG = 7;
    localparam int EV_REINIT = 8;
    localparam int EV_REQUEST = 9;
    localparam int N_EV = 10;
    // adjustment channels
    localparam int CH_VOLT = 0;
    localparam int CH_FREQ = 1;
    typedef enum logic [1:0] {S_IDLE, S_RUN, S_CLOSE, S_BLOCKED} gsc_state_t;
endpackage

// ### hdl/gsc_sync_ctrl.sv
// generator synchronizer control: start gating, raise/lower pulses, breaker close and events
`timescale 1ns/1ps
module gsc_sync_ctrl import gsc_pkg::*; #(
    parameter int unsigned PROG_CYCLES = PROG_CYCLE_CLKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // settings, 0.01 units; vlen_const and flen_const in 1/1024 program cycles
    input wire logic [SET_W-1:0] vdiff_max,
    input wire logic signed [SET_W-1:0] vup_lim,
    input wire logic signed [SET_W-1:0] vdn_lim,
    input wire logic signed [SET_W-1:0] vint_thr,
    input wire logic [LEN_W-1:0] vlen_const,
    input wire logic [SET_W-1:0] fdiff_max,
    input wire logic signed [SET_W-1:0] fint_thr,
    input wire logic [LEN_W-1:0] flen_const,
    input wire logic signed [SET_W-1:0] preclose,
    input wire logic signed [SET_W-1:0] angle_win,
    // settings, program cycles, and the multi_close switch
    input wire logic [TIME_W-1:0] filt_cycles,
    input wire logic [TIME_W-1:0] close_len,
    input wire logic [TIME_W-1:0] max_sync,
    input wire logic multi_close,
    // measurements, same clock
    input wire logic signed [SET_W-1:0] volt_diff,
    input wire logic signed [SET_W-1:0] volt_ctl,
    input wire logic signed [SET_W-1:0] freq_diff,
    input wire logic signed [SET_W-1:0] angle_diff,
    // control
    input wire logic sync_req,
    input wire logic block_pin,
    input wire logic brk_closed_pin,
    // event selection
    input wire logic [N_EV-1:0] evt_sel_on,
    input wire logic [N_EV-1:0] evt_sel_off,
    // adjustment and breaker commands
    output logic volt_raise,
    output logic volt_lower,
    output logic freq_raise,
    output logic freq_lower,
    output logic brk_close,
    // status
    output logic sync_blocked,
    output logic sync_running,
    output logic long_sync,
    output logic close_fail,
    output logic prog_tick,
    // events
    output logic [N_EV-1:0] evt_on,
    output logic [N_EV-1:0] evt_off,
    output logic [STAMP_W-1:0] evt_stamp
);
    localparam int CNT_W = $clog2(PROG_CYCLES);

    if (PROG_CYCLES < 2) begin : g_bad_cycle
        $error("PROG_CYCLES must be at least 2");
    end

    function automatic logic [SET_W-1:0] mag(input logic signed [SET_W-1:0] v);
        return (v < 0) ? SET_W'(-v) : SET_W'(v);
    endfunction

    function automatic logic [LEN_W-1:0] pulse_len(input logic [LEN_W-1:0] c);
        logic [LEN_W-1:0] s;
        s = c >> LEN_SHIFT;
        return (s == '0) ? LEN_W'(1) : s;
    endfunction

    // program cycle timing
    logic [CNT_W-1:0] tick_cnt;
    logic step;
    logic [STAMP_W-1:0] stamp;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tick_cnt <= '0;
            prog_tick <= 1'b0;
            step <= 1'b0;
            stamp <= '0;
        end else begin
            prog_tick <= (tick_cnt == CNT_W'(PROG_CYCLES - 1));
            tick_cnt <= (tick_cnt == CNT_W'(PROG_CYCLES - 1)) ? '0 : tick_cnt + CNT_W'(1);
            step <= prog_tick;
            if (prog_tick) begin
                stamp <= stamp + STAMP_W'(1);
            end
        end
    end

    // pin inputs: bit 0 blocking, bit 1 breaker closed
    logic [1:0] sy1, sy2, sy3, pin_f;
    logic blk;
    wire [1:0] pin_agree = ~(sy2 ^ sy3);
    wire [1:0] next_pin_f = (sy2 & pin_agree) | (pin_f & ~pin_agree);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sy1 <= '0;
            sy2 <= '0;
            sy3 <= '0;
            pin_f <= '0;
            blk <= 1'b0;
        end else begin
            sy1 <= {brk_closed_pin, block_pin};
            sy2 <= sy1;
            sy3 <= sy2;
            pin_f <= next_pin_f;
            // taken once at the cycle start, so a late block waits a full cycle
            if (prog_tick) begin
                blk <= pin_f[0];
            end
        end
    end

    // start permission
    wire v_ok = mag(volt_diff) <= vdiff_max;
    wire f_ok = mag(freq_diff) <= fdiff_max;
    wire permit = sync_req && v_ok && f_ok;

    // angle slope over the filter window and projected close angle
    logic [TIME_W-1:0] win_cnt;
    logic signed [SET_W-1:0] angle_mark, slip;
    logic slip_valid;
    wire win_end = (win_cnt + TIME_W'(1)) >= filt_cycles;
    wire signed [PROD_W-1:0] prod = PROD_W'(slip) * PROD_W'(preclose);
    wire signed [PROD_W-1:0] pred = PROD_W'(angle_diff) + (prod >>> PRE_SHIFT);
    wire pred_ok = (pred <= PROD_W'(angle_win)) && (pred >= -PROD_W'(angle_win));

    always_ff @(posedge core_clk) begin
        if (!rstn || !sync_running) begin
            win_cnt <= '0;
            angle_mark <= angle_diff;
            slip <= '0;
            slip_valid <= 1'b0;
        end else if (step) begin
            win_cnt <= win_end ? '0 : win_cnt + TIME_W'(1);
            if (win_end) begin
                slip <= angle_diff - angle_mark;
                angle_mark <= angle_diff;
                slip_valid <= 1'b1;
            end
        end
    end

    // sequence control
    gsc_state_t state, next_state;
    logic [TIME_W-1:0] run_t, close_t;
    wire sync_late = run_t >= max_sync;
    wire close_end = (close_t + TIME_W'(1)) >= close_len;
    wire close_ok = permit && slip_valid && pred_ok;
    wire brk_done = pin_f[1];

    always_comb begin
        next_state = state;
        if (step) begin
            unique case (state)
                S_IDLE: begin
                    if (permit) begin
                        next_state = blk ? S_BLOCKED : S_RUN;
                    end
                end
                S_RUN: begin
                    if (blk) begin
                        next_state = S_BLOCKED;
                    end else if (!sync_req || sync_late) begin
                        next_state = S_IDLE;
                    end else if (close_ok) begin
                        next_state = S_CLOSE;
                    end
                end
                S_CLOSE: begin
                    if (close_end) begin
                        next_state = (brk_done || !multi_close) ? S_IDLE : S_RUN;
                    end
                end
                S_BLOCKED: begin
                    if (!blk) begin
                        next_state = S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= S_IDLE;
            sync_blocked <= 1'b0;
            sync_running <= 1'b0;
            brk_close <= 1'b0;
            run_t <= '0;
            close_t <= '0;
            long_sync <= 1'b0;
            close_fail <= 1'b0;
        end else begin
            state <= next_state;
            sync_blocked <= (next_state == S_BLOCKED);
            sync_running <= (next_state == S_RUN) || (next_state == S_CLOSE);
            brk_close <= (next_state == S_CLOSE);
            if (step) begin
                run_t <= (state == S_IDLE) ? '0 : run_t + TIME_W'(1);
                close_t <= (state == S_CLOSE) ? close_t + TIME_W'(1) : '0;
            end
            if (state == S_IDLE && next_state == S_RUN) begin
                long_sync <= 1'b0;
                close_fail <= 1'b0;
            end
            if (state == S_RUN && next_state == S_IDLE && sync_late && sync_req && !blk) begin
                long_sync <= 1'b1;
            end
            // breaker did not report closed: retried only with multi_close
            if (state == S_CLOSE && step && close_end && !brk_done) begin
                close_fail <= 1'b1;
            end
        end
    end

    // raise and lower channels
    logic signed [SET_W-1:0] ch_err [2];
    logic signed [SET_W-1:0] ch_thr [2];
    logic [LEN_W-1:0] ch_const [2];
    logic ch_up_ok [2];
    logic ch_dn_ok [2];
    logic [1:0] raise_q, lower_q;

    assign ch_err[CH_VOLT] = volt_diff;
    assign ch_err[CH_FREQ] = freq_diff;
    assign ch_thr[CH_VOLT] = vint_thr;
    assign ch_thr[CH_FREQ] = fint_thr;
    assign ch_const[CH_VOLT] = vlen_const;
    assign ch_const[CH_FREQ] = flen_const;
    assign ch_up_ok[CH_VOLT] = volt_ctl < vup_lim;
    assign ch_dn_ok[CH_VOLT] = volt_ctl > vdn_lim;
    assign ch_up_ok[CH_FREQ] = 1'b1;
    assign ch_dn_ok[CH_FREQ] = 1'b1;

    for (genvar c = 0; c < 2; c++) begin : g_adj
        logic signed [ACC_W-1:0] acc;
        logic [LEN_W-1:0] cnt;
        wire signed [ACC_W-1:0] sum = acc + ACC_W'(ch_err[c]);
        wire signed [ACC_W-1:0] thr = ACC_W'(ch_thr[c]);
        wire fire_up = sum >= thr;
        wire fire_dn = sum <= -thr;

        // the sum is held while a pulse runs, so a pulse is never stretched
        always_ff @(posedge core_clk) begin
            if (!rstn || !sync_running) begin
                acc <= '0;
                cnt <= '0;
                raise_q[c] <= 1'b0;
                lower_q[c] <= 1'b0;
            end else if (step) begin
                if (cnt != '0) begin
                    cnt <= cnt - LEN_W'(1);
                    if (cnt == LEN_W'(1)) begin
                        raise_q[c] <= 1'b0;
                        lower_q[c] <= 1'b0;
                    end
                end else if (fire_up || fire_dn) begin
                    acc <= '0;
                    if (fire_up ? ch_up_ok[c] : ch_dn_ok[c]) begin
                        cnt <= pulse_len(ch_const[c]);
                        raise_q[c] <= fire_up;
                        lower_q[c] <= !fire_up;
                    end
                end else begin
                    acc <= sum;
                end
            end
        end
    end

    assign volt_raise = raise_q[CH_VOLT];
    assign volt_lower = lower_q[CH_VOLT];
    assign freq_raise = raise_q[CH_FREQ];
    assign freq_lower = lower_q[CH_FREQ];

    // events
    logic req_q;
    logic [N_EV-1:0] st_prev;
    logic [N_EV-1:0] st;

    assign st[EV_BLOCKED] = sync_blocked;
    assign st[EV_RUNNING] = sync_running;
    assign st[EV_VRAISE] = raise_q[CH_VOLT];
    assign st[EV_VLOWER] = lower_q[CH_VOLT];
    assign st[EV_FRAISE] = raise_q[CH_FREQ];
    assign st[EV_FLOWER] = lower_q[CH_FREQ];
    assign st[EV_CLOSE] = brk_close;
    assign st[EV_LONG] = long_sync;
    assign st[EV_REINIT] = close_fail;
    assign st[EV_REQUEST] = req_q;

    wire [N_EV-1:0] rise = st & ~st_prev;
    wire [N_EV-1:0] fall = ~st & st_prev;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            req_q <= 1'b0;
            st_prev <= '0;
            evt_on <= '0;
            evt_off <= '0;
            evt_stamp <= '0;
        end else begin
            if (step) begin
                req_q <= sync_req;
            end
            st_prev <= st;
            evt_on <= rise & evt_sel_on;
            evt_off <= fall & evt_sel_off;
            if ((rise | fall) != '0) begin
                evt_stamp <= stamp;
            end
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_start_vdiff: assert property ($rose(sync_running) |-> $past(v_ok))
        else $error("sequence started with voltage difference over limit");
    a_start_fdiff: assert property ($rose(sync_running) |-> $past(f_ok))
        else $error("sequence started with frequency difference over limit");
    a_raise_high: assert property ($rose(volt_raise) |-> $past(ch_up_ok[CH_VOLT]))
        else $error("voltage raise issued above upper limit");
    a_lower_low: assert property ($rose(volt_lower) |-> $past(ch_dn_ok[CH_VOLT]))
        else $error("voltage lower issued below lower limit");
    a_block_hold: assert property (!prog_tick |=> $stable(blk))
        else $error("blocking sample changed inside a program cycle");
    a_blocked_entry: assert property (step && state == S_IDLE && permit && blk
        |=> sync_blocked && !sync_running && !brk_close)
        else $error("blocked start did not give blocked indication");
    a_close_cause: assert property ($rose(brk_close) |-> $past(state) == S_RUN && !$past(blk))
        else $error("close pulse without running unblocked sequence");
    a_event_rise: assert property (evt_on[EV_CLOSE] |-> $past(brk_close) && !$past(brk_close, 2))
        else $error("close on event not tied to close rise");
    a_event_sel: assert property ((evt_off & ~$past(evt_sel_off)) == '0)
        else $error("off event stored while deselected");
    a_event_stamp: assert property ((evt_on | evt_off) != '0 |-> evt_stamp == $past(stamp))
        else $error("event stamp does not match cycle count");

    c_close: cover property ($rose(brk_close));
    c_blocked: cover property ($rose(sync_blocked));
    c_freq_raise: cover property ($rose(freq_raise));
    c_long: cover property ($rose(long_sync));
endmodule // gsc_sync_ctrl

// ### bench/gsc_brk_model.sv
// breaker model on the far side of the synchronizer control block
`timescale 1ns/1ps
module gsc_brk_model #(
    parameter int CLOSE_DLY = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // commands from the block and the bench
    input wire logic brk_close,
    input wire logic fail_close,
    input wire logic trip,
    // breaker position
    output logic brk_closed_pin
);
    int unsigned hold;
    // mechanism needs the close coil held a few clocks; a stuck breaker never moves
    always @(posedge core_clk) begin
        if (!rstn || trip) begin
            hold <= 0;
            brk_closed_pin <= 1'b0;
        end else if (brk_close && !fail_close) begin
            hold <= hold + 1;
            if (hold + 1 >= CLOSE_DLY) begin
                brk_closed_pin <= 1'b1;
            end
        end else begin
            hold <= 0;
        end
    end
endmodule // gsc_brk_model

// ### bench/testbench.sv
// self-checking bench of the synchronizer control block
`timescale 1ns/1ps
module testbench;
    import gsc_pkg::*;
    // short program cycle keeps the run small
    localparam int P = 10;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [SET_W-1:0] vdiff_max = DEF_VDIFF_MAX;
    logic [SET_W-1:0] fdiff_max = DEF_FDIFF_MAX;
    logic signed [SET_W-1:0] vup_lim = DEF_VUP_LIM;
    logic signed [SET_W-1:0] vdn_lim = DEF_VDN_LIM;
    logic signed [SET_W-1:0] vint_thr = 16'h0200;
    logic signed [SET_W-1:0] fint_thr = 16'h0020;
    logic signed [SET_W-1:0] preclose = 16'h0000;
    logic signed [SET_W-1:0] angle_win = 16'h0064;
    logic [LEN_W-1:0] vlen_const = 20'h00C00;
    logic [LEN_W-1:0] flen_const = 20'h00400;
    logic [TIME_W-1:0] filt_cycles = 20'h00002;
    logic [TIME_W-1:0] close_len = 20'h00002;
    logic [TIME_W-1:0] max_sync = 20'h00FFF;
    logic multi_close = 1'b0;
    logic sync_req = 1'b0;
    logic block_pin = 1'b0;
    logic fail_close = 1'b0;
    logic trip = 1'b0;
    logic signed [SET_W-1:0] volt_diff = 16'h0000;
    logic signed [SET_W-1:0] volt_ctl = 16'h0000;
    logic signed [SET_W-1:0] freq_diff = 16'h0000;
    logic signed [SET_W-1:0] angle_diff = 16'h4000;
    logic [N_EV-1:0] evt_sel_on = 10'h3FF;
    logic [N_EV-1:0] evt_sel_off = 10'h3FF;
    logic volt_raise, volt_lower, freq_raise, freq_lower, brk_close, brk_closed_pin;
    logic sync_blocked, sync_running, long_sync, close_fail, prog_tick;
    logic [N_EV-1:0] evt_on, evt_off;
    logic [STAMP_W-1:0] evt_stamp;
    logic clr = 1'b0;
    logic [N_EV-1:0] seen_on, seen_off;
    logic [31:0] run [4];
    logic [31:0] last [4];
    logic [3:0] any;
    int errors = 0;
    int cmp_count = 0;
    wire [3:0] mon = {brk_close, freq_raise, volt_lower, volt_raise};

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    gsc_sync_ctrl #(.PROG_CYCLES(P)) i_gsc_sync_ctrl (.core_clk(core_clk), .rstn(rstn),
        .vdiff_max(vdiff_max), .vup_lim(vup_lim), .vdn_lim(vdn_lim), .vint_thr(vint_thr),
        .vlen_const(vlen_const), .fdiff_max(fdiff_max), .fint_thr(fint_thr), .flen_const(flen_const),
        .preclose(preclose), .angle_win(angle_win), .filt_cycles(filt_cycles), .close_len(close_len),
        .max_sync(max_sync), .multi_close(multi_close), .volt_diff(volt_diff), .volt_ctl(volt_ctl),
        .freq_diff(freq_diff), .angle_diff(angle_diff), .sync_req(sync_req), .block_pin(block_pin),
        .brk_closed_pin(brk_closed_pin), .evt_sel_on(evt_sel_on), .evt_sel_off(evt_sel_off),
        .volt_raise(volt_raise), .volt_lower(volt_lower), .freq_raise(freq_raise), .freq_lower(freq_lower),
        .brk_close(brk_close), .sync_blocked(sync_blocked), .sync_running(sync_running),
        .long_sync(long_sync), .close_fail(close_fail), .prog_tick(prog_tick), .evt_on(evt_on),
        .evt_off(evt_off), .evt_stamp(evt_stamp));

    gsc_brk_model i_gsc_brk_model (.core_clk(core_clk), .rstn(rstn), .brk_close(brk_close),
        .fail_close(fail_close), .trip(trip), .brk_closed_pin(brk_closed_pin));

    // event and pulse-length monitor; last[] keeps the length of the latest finished pulse
    always @(posedge core_clk) begin
        seen_on <= clr ? 10'h000 : (seen_on | evt_on);
        seen_off <= clr ? 10'h000 : (seen_off | evt_off);
        for (int i = 0; i < 4; i++) begin
            any[i] <= clr ? 1'b0 : (any[i] | mon[i]);
            run[i] <= (clr || !mon[i]) ? 32'h0 : run[i] + 1;
            if (clr) last[i] <= 32'h0;
            else if (!mon[i] && run[i] != 0) last[i] <= run[i];
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic clear();
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
    endtask

    task automatic stop_run();
        sync_req = 1'b0;
        tick(3 * P);
    endtask

    task automatic t_start_limits();
        volt_diff = 16'h07D1;
        sync_req = 1'b1;
        tick(3 * P);
        chk(sync_running, 1'b0);
        volt_diff = 16'h07D0;
        tick(3 * P);
        chk(sync_running, 1'b1);
        stop_run();
        volt_diff = 16'h0000;
        freq_diff = 16'h01F5;
        sync_req = 1'b1;
        tick(3 * P);
        chk(sync_running, 1'b0);
        freq_diff = 16'hFE0C;
        tick(3 * P);
        chk(sync_running, 1'b1);
        stop_run();
        freq_diff = 16'h0000;
    endtask

    task automatic t_volt_adjust();
        volt_diff = 16'h0100;
        clear();
        sync_req = 1'b1;
        tick(15 * P);
        chk(last[0], 3 * P);
        chk(any[1], 1'b0);
        volt_ctl = DEF_VUP_LIM;
        tick(4 * P);
        clear();
        tick(12 * P);
        chk(any[0], 1'b0);
        volt_diff = 16'hFF00;
        volt_ctl = vdn_lim;
        tick(4 * P);
        clear();
        tick(12 * P);
        chk(any[1], 1'b0);
        volt_ctl = 16'h0000;
        tick(15 * P);
        chk(last[1], 3 * P);
        stop_run();
        volt_diff = 16'h0000;
    endtask

    task automatic t_freq_adjust();
        freq_diff = 16'h0010;
        clear();
        sync_req = 1'b1;
        tick(12 * P);
        chk(last[2], P);
        freq_diff = 16'hFFF0;
        clear();
        tick(12 * P);
        chk(seen_on[EV_FLOWER], 1'b1);
        chk(seen_off[EV_FLOWER], 1'b1);
        stop_run();
        freq_diff = 16'h0000;
        // short time limit: the run is dropped and the long-time flag raised
        max_sync = 20'h00004;
        clear();
        sync_req = 1'b1;
        tick(8 * P);
        chk(seen_on[EV_LONG], 1'b1);
        stop_run();
        max_sync = 20'h00FFF;
    endtask

    task automatic t_blocked();
        evt_sel_on = 10'h3FE;
        block_pin = 1'b1;
        tick(3 * P);
        clear();
        sync_req = 1'b1;
        tick(3 * P);
        chk(sync_blocked, 1'b1);
        chk(sync_running, 1'b0);
        chk(seen_on[EV_BLOCKED], 1'b0);
        block_pin = 1'b0;
        tick(3 * P);
        chk(sync_blocked, 1'b0);
        chk(seen_off[EV_BLOCKED], 1'b1);
        stop_run();
        evt_sel_on = 10'h3FF;
    endtask

    task automatic t_close();
        int k;
        logic [STAMP_W-1:0] s0;
        for (int f = 0; f < 2; f++) begin
            fail_close = f[0];
            angle_diff = 16'h0000;
            s0 = evt_stamp;
            clear();
            sync_req = 1'b1;
            k = 0;
            while (brk_close !== 1'b1 && k < 40 * P) begin
                tick(1);
                k++;
            end
            sync_req = 1'b0;
            tick(4 * P);
            chk(last[3], 2 * P);
            chk({seen_on[EV_CLOSE], seen_on[EV_RUNNING]}, 2'b11);
            chk(close_fail, f[0]);
            chk(evt_stamp > s0, 1'b1);
            trip = 1'b1;
            tick(2);
            trip = 1'b0;
            angle_diff = 16'h4000;
        end
        fail_close = 1'b0;
    endtask

    task automatic close_out();
        $display("errors=%0d cmp_count=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole sequence needs well under 4000 clocks
    initial begin
        #100000;
        errors++;
        close_out();
    end

    initial begin
        tick(10);
        chk({mon, sync_blocked, sync_running, close_fail, evt_on, evt_off}, 32'h0);
        rstn = 1'b1;
        tick(4);
        @(posedge prog_tick);
        tick(P + 1);
        chk(prog_tick, 1'b1);
        t_start_limits();
        t_volt_adjust();
        t_freq_adjust();
        t_blocked();
        t_close();
        close_out();
    end
endmodule // testbench
